// File: verilog/reset_boot_and_device_id.sv
// Top of reset, boot-status and identity logic.
// Assumes resetn is the power-on reset; the reset pin arrives asynchronously.
`timescale 1ns/100ps
module reset_boot_and_device_id #(
  parameter logic [15:0] DEVICE_ID  = 16'hA5C3, // Arbitrary value
  parameter logic [7:0]  SILICON_REV = 8'h00,
  parameter logic [7:0]  DRIVER_REV  = 8'h00
) (
  input  wire logic                sys_clk,        // 250 MHz core clock
  input  wire logic                resetn,         // Power-on reset, active low
  input  wire logic                clk_en,         // Clock enable
  input  wire logic                rst_pin_in,     // Reset pin level
  input  wire logic                rst_pin_driven, // Reset pin driven externally
  input  wire logic                sleep_req,      // Core in sleep, from supply logic
  input  wire rst_boot_pkg::reg_req_t req,         // Register request
  output logic [15:0]              rdata,          // Read data, registered
  output logic                     rvalid,         // Read data valid
  output rst_boot_pkg::pad_ctrl_t  rst_pad,        // Reset pad controls
  output logic                     irq_n,          // Interrupt pin, active low
  output logic                     gpio_boot,      // Boot flag on GPIO
  output logic                     boot_complete_flag, // Boot done level
  output logic                     core_rst_n,     // Core reset, active low
  output logic                     mic_analogue_a, // Mic pair A analogue
  output logic                     mic_analogue_b, // Mic pair B analogue
  output logic                     digital_mic_clock_a_en, // Dmic clock A drive
  output logic                     digital_mic_clock_b_en  // Dmic clock B drive
);
  import rst_boot_pkg::*;

  logic [1:0]        pad_q;       // Always-on domain
  logic              mask_q;      // Always-on domain
  logic [1:0]        mic_q;
  logic [15:0]       seq_mem_q [SEQ_DEPTH];
  boot_state_t       st_q;
  logic [15:0]       cnt_q;
  logic              pin_sync;
  logic              sleep_meta_q;
  logic              sleep_q;
  logic              wake_q;
  logic              soft_q;
  logic [15:0]       rdata_q;
  logic              rvalid_q;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  reset_pad_keeper u_pad (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .clk_en     (clk_en),
    .pin_in     (rst_pin_in),
    .pin_driven (rst_pin_driven),
    .pad_bits   (pad_q),
    .pad        (rst_pad),
    .pin_sync   (pin_sync)
  );

  wire hw_rst   = ~pin_sync;
  wire in_reset = hw_rst | soft_q | sleep_q;
  wire ready    = (st_q == ST_READY);
  // Flag drops with the reset source itself, not one cycle later
  wire boot_done = ready & ~in_reset;
  // Writes before boot completes are dropped, matching host obligation
  wire wr_ok    = req.wr & ready & ~in_reset;
  wire wr_id    = wr_ok & hit(req.addr, ADDR_SOFT_RESET_AND_IDENTITY);
  wire wr_pad   = wr_ok & hit(req.addr, ADDR_RESET_PAD_CONTROL);
  wire wr_mic   = wr_ok & hit(req.addr, ADDR_MIC_PIN_CONTROL);
  wire wr_mask  = wr_ok & hit(req.addr, ADDR_IRQ_MASK_5);
  wire seq_hit  = (req.addr[15:SEQ_AW] == ADDR_SEQ_MEM_BASE[15:SEQ_AW]);
  wire wr_seq   = wr_ok & seq_hit;
  wire [SEQ_AW-1:0] seq_idx = req.addr[SEQ_AW-1:0];
  wire [1:0]        pad_wdata = req.wdata[1:0];

  // Sleep level from supply logic is asynchronous
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_meta_q <= 1'b0;
      sleep_q      <= 1'b0;
    end else if (clk_en) begin
      sleep_meta_q <= sleep_req;
      sleep_q      <= sleep_meta_q;
    end
  end

  // Software reset lasts one cycle; wake marks the sleep exit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      soft_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      soft_q <= wr_id;
      wake_q <= sleep_q | (wake_q & ~ready);
    end
  end

  // Always-on registers: only power-on clears them
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pad_q  <= PAD_RESET;
      mask_q <= MASK_RESET;
    end else if (clk_en) begin
      if (wr_pad)
        pad_q <= pad_wdata;
      if (wr_mask)
        mask_q <= req.wdata[BOOT_DONE_BIT];
    end
  end

  // Core registers return to defaults on every reset kind
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mic_q <= MIC_RESET;
    end else if (clk_en) begin
      if (in_reset)
        mic_q <= MIC_RESET;
      else if (wr_mic)
        mic_q <= req.wdata[1:0];
    end
  end

  // Sequencer memory: no reset term besides power-on
  genvar g;
  generate
    for (g = 0; g < SEQ_DEPTH; g++) begin : g_seq
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
          seq_mem_q[g] <= 16'h0000;
        else if (clk_en && wr_seq && seq_idx == SEQ_AW'(g))
          seq_mem_q[g] <= req.wdata;
      end
    end
  endgenerate

  // Boot sequencer: stays in reset while any source holds, then counts
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q  <= ST_BOOT;
      cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (in_reset) begin
        st_q  <= ST_RESET;
        cnt_q <= 16'h0000;
      end else begin
        unique case (st_q)
          ST_RESET: begin
            st_q  <= ST_BOOT;
            cnt_q <= 16'h0000;
          end
          ST_BOOT: begin
            if (cnt_q == 16'(BOOT_CYCLES - 1))
              st_q <= ST_READY;
            else
              cnt_q <= cnt_q + 16'h0001;
          end
          ST_READY: st_q <= ST_READY;
          default:  st_q <= ST_RESET;
        endcase
      end
    end
  end

  // Read mux; identity replaces whatever was written at offset zero
  wire [15:0] rd_mux =
      hit(req.addr, ADDR_SOFT_RESET_AND_IDENTITY) ? DEVICE_ID :
      hit(req.addr, ADDR_SILICON_REVISION)        ? {8'h00, SILICON_REV} :
      hit(req.addr, ADDR_DRIVER_REVISION)         ? {8'h00, DRIVER_REV} :
      hit(req.addr, ADDR_RESET_PAD_CONTROL)       ? {14'h0000, pad_q} :
      hit(req.addr, ADDR_RAW_IRQ_STATUS_5)        ? 16'(boot_done) << BOOT_DONE_BIT :
      hit(req.addr, ADDR_IRQ_MASK_5)              ? 16'(mask_q) << BOOT_DONE_BIT :
      hit(req.addr, ADDR_MIC_PIN_CONTROL)         ? {14'h0000, mic_q} :
      seq_hit                                     ? seq_mem_q[seq_idx] :
                                                    16'h0000;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= req.rd;
      if (req.rd)
        rdata_q <= rd_mux;
    end
  end

  assign rdata              = rdata_q;
  assign rvalid             = rvalid_q;
  assign boot_complete_flag = boot_done;
  assign gpio_boot          = boot_done;
  // Default mask passes the flag; pin falls when boot completes
  assign irq_n              = ~(boot_done & ~mask_q);
  assign core_rst_n         = ~in_reset;
  assign mic_analogue_a     = ~mic_q[MIC_DIG_A_BIT];
  assign mic_analogue_b     = ~mic_q[MIC_DIG_B_BIT];
  assign digital_mic_clock_a_en = mic_q[MIC_DIG_A_BIT] & ready;
  assign digital_mic_clock_b_en = mic_q[MIC_DIG_B_BIT] & ready;

  property p_hw_holds;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && !pin_sync) |=> (st_q == ST_RESET);
  endproperty
  a_hw_holds: assert property (p_hw_holds) else $error("Pin low but not in reset");

  property p_soft;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && wr_id) |=> soft_q ##1 (st_q == ST_RESET || !clk_en);
  endproperty
  a_soft: assert property (p_soft) else $error("Write to zero gave no reset");

  property p_flag_low;
    @(posedge sys_clk) disable iff (!resetn)
      (st_q != ST_READY) |-> !boot_complete_flag;
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("Boot flag early");

  property p_boot_len;
    @(posedge sys_clk) disable iff (!resetn)
      (st_q == ST_BOOT && cnt_q == 16'h0000 && clk_en && !in_reset)
        |-> !ready [*8];
  endproperty
  a_boot_len: assert property (p_boot_len) else $error("Boot too short");

  property p_irq;
    @(posedge sys_clk) disable iff (!resetn)
      ($rose(boot_complete_flag) && !mask_q) |-> $fell(irq_n);
  endproperty
  a_irq: assert property (p_irq) else $error("No falling irq at boot done");

  property p_pad_keep;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && wr_pad) |=> (pad_q == $past(pad_wdata));
  endproperty
  a_pad_keep: assert property (p_pad_keep) else $error("Pad write lost");

  property p_pad_survive;
    @(posedge sys_clk) disable iff (!resetn)
      in_reset |=> $stable(pad_q);
  endproperty
  a_pad_survive: assert property (p_pad_survive) else $error("Always-on reg reset");

  property p_seq_keep;
    @(posedge sys_clk) disable iff (!resetn)
      in_reset |=> $stable(seq_mem_q[0]);
  endproperty
  a_seq_keep: assert property (p_seq_keep) else $error("Sequencer memory lost");

  property p_id;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && req.rd && req.addr == ADDR_SOFT_RESET_AND_IDENTITY)
        |=> (rvalid && rdata == DEVICE_ID);
  endproperty
  a_id: assert property (p_id) else $error("Identity read wrong");

  property p_mic;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && in_reset) |=> (mic_analogue_a && mic_analogue_b);
  endproperty
  a_mic: assert property (p_mic) else $error("Mic pin not analogue after reset");

  property p_flag_reset;
    @(posedge sys_clk) disable iff (!resetn)
      in_reset |-> !boot_complete_flag;
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("Boot flag high in reset");

  property p_wake_mask;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && wake_q && !ready) |=> $stable(mask_q);
  endproperty
  a_wake_mask: assert property (p_wake_mask) else $error("Always-on mask moved in wake");

  property p_raw_status;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && req.rd && req.addr == ADDR_RAW_IRQ_STATUS_5)
        |=> (rvalid && rdata[BOOT_DONE_BIT] == $past(boot_complete_flag));
  endproperty
  a_raw_status: assert property (p_raw_status) else $error("Raw status read wrong");

  property p_silicon_rev;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && req.rd && req.addr == ADDR_SILICON_REVISION)
        |=> (rvalid && rdata == {8'h00, SILICON_REV});
  endproperty
  a_silicon_rev: assert property (p_silicon_rev) else $error("Silicon rev read wrong");

  property p_driver_rev;
    @(posedge sys_clk) disable iff (!resetn)
      (clk_en && req.rd && req.addr == ADDR_DRIVER_REVISION)
        |=> (rvalid && rdata == {8'h00, DRIVER_REV});
  endproperty
  a_driver_rev: assert property (p_driver_rev) else $error("Driver rev read wrong");

  property p_keeper_pulls;
    @(posedge sys_clk) disable iff (!resetn)
      (pad_q == 2'h3) |-> (rst_pad.keep_en && !rst_pad.pu_en && !rst_pad.pd_en);
  endproperty
  a_keeper_pulls: assert property (p_keeper_pulls) else $error("Keeper not selected");

  property p_pull_only;
    @(posedge sys_clk) disable iff (!resetn)
      (pad_q != 2'h3) |-> (!rst_pad.keep_en &&
                           rst_pad.pu_en == pad_q[PULLUP_BIT] &&
                           rst_pad.pd_en == pad_q[PULLDOWN_BIT]);
  endproperty
  a_pull_only: assert property (p_pull_only) else $error("Pull enable wrong");
endmodule

// File: verilog/rst_boot_pkg.sv
// Constants, layouts and types for the reset, boot and identity block.
// Assumes one 250 MHz core clock and a simple word-wide register port.
package rst_boot_pkg;
  localparam logic [15:0] ADDR_SOFT_RESET_AND_IDENTITY = 16'h0000;
  localparam logic [15:0] ADDR_SILICON_REVISION        = 16'h0001;
  localparam logic [15:0] ADDR_DRIVER_REVISION         = 16'h0002;
  localparam logic [15:0] ADDR_RESET_PAD_CONTROL       = 16'h0C20;
  localparam logic [15:0] ADDR_RAW_IRQ_STATUS_5        = 16'h0D23;
  localparam logic [15:0] ADDR_MIC_PIN_CONTROL         = 16'h0C30;
  localparam logic [15:0] ADDR_IRQ_MASK_5              = 16'h0D33;
  localparam logic [15:0] ADDR_SEQ_MEM_BASE            = 16'h3000;
  localparam int          PULLUP_BIT                   = 1;
  localparam int          PULLDOWN_BIT                 = 0;
  localparam int          BOOT_DONE_BIT                = 8;
  localparam int          MIC_DIG_A_BIT                = 0;
  localparam int          MIC_DIG_B_BIT                = 1;
  localparam logic [1:0]  PAD_RESET                    = 2'h2;
  localparam logic [1:0]  MIC_RESET                    = 2'h0;
  localparam logic        MASK_RESET                   = 1'h0;
  localparam int          SEQ_DEPTH                    = 16;
  localparam int          SEQ_AW                       = 4;
  localparam int          BOOT_STEPS                   = 16;
  localparam int          BOOT_TIME_NS                 = 1000;
  localparam int          CLK_PERIOD_NS                = 4;
  localparam int          BOOT_CYCLES                  = (BOOT_TIME_NS + CLK_PERIOD_NS - 1)
                                                         / CLK_PERIOD_NS;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        pu_en;
    logic        pd_en;
    logic        keep_en;
    logic        drive;
  } pad_ctrl_t;

  typedef enum logic [1:0] {ST_RESET, ST_BOOT, ST_READY} boot_state_t;
endpackage

// File: verilog/reset_pad_keeper.sv
// Reset pin conditioner: pull options, bus keeper and synchroniser.
// Assumes the pad cell applies pu/pd and the keeper drive; pin is async.
`timescale 1ns/100ps
module reset_pad_keeper (
  input  wire logic                  sys_clk,    // Core clock
  input  wire logic                  resetn,     // Power-on reset, active low
  input  wire logic                  clk_en,     // Freezes state when low
  input  wire logic                  pin_in,     // Raw reset pin level
  input  wire logic                  pin_driven, // External driver active
  input  wire logic [1:0]            pad_bits,   // Pull-up, pull-down enables
  output rst_boot_pkg::pad_ctrl_t    pad,        // Pad control outputs
  output logic                       pin_sync    // Synchronised pin level
);
  import rst_boot_pkg::*;
  logic meta_q;
  logic sync_q;
  logic keep_q;
  wire  keep_on = pad_bits[PULLUP_BIT] & pad_bits[PULLDOWN_BIT];
  // Released line resolves to pull value, or last level when keeping
  wire  level   = pin_driven ? pin_in :
                  keep_on    ? keep_q :
                  pad_bits[PULLUP_BIT] ? 1'b1 :
                  pad_bits[PULLDOWN_BIT] ? 1'b0 : pin_in;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      keep_q <= 1'b1;
    end else if (clk_en) begin
      meta_q <= level;
      sync_q <= meta_q;
      keep_q <= sync_q;
    end
  end

  assign pin_sync    = sync_q;
  assign pad.pu_en   = pad_bits[PULLUP_BIT] & ~keep_on;
  assign pad.pd_en   = pad_bits[PULLDOWN_BIT] & ~keep_on;
  assign pad.keep_en = keep_on;
  assign pad.drive   = keep_q;
endmodule

// File: test/host_reset_pin.sv
// Host side of the reset pin: drives, releases, or leaves the line to the pad.
// Assumes pad controls come straight from the device's reset pad outputs.
`timescale 1ns/100ps
module host_reset_pin (
  input  wire logic                    drive_en,  // Host drives the pin
  input  wire logic                    drive_lvl, // Level the host drives
  input  wire rst_boot_pkg::pad_ctrl_t pad,       // Device pad controls
  output logic                         pin_level, // Resolved pin level
  output logic                         pin_driven // Host driver active
);
  import rst_boot_pkg::*;
  logic last_lvl = 1'b1;
  // No serial bus part or regulator pin modelled, so nothing to prepare
  always @(drive_en or drive_lvl) begin
    if (drive_en) begin
      last_lvl = drive_lvl;
    end
  end
  assign pin_driven = drive_en;
  // Undriven, unpulled line shows the inverse, so a stale level never passes
  assign pin_level = drive_en    ? drive_lvl :
                     pad.keep_en ? pad.drive :
                     pad.pu_en   ? 1'b1 :
                     pad.pd_en   ? 1'b0 : ~last_lvl;
endmodule

// File: test/test_reset_boot_and_device_id.sv
// Self-checking bench for the reset, boot and identity block.
// Assumes a host model on the reset pin and the word-wide request port.
`timescale 1ns/100ps
module test_reset_boot_and_device_id;
  import rst_boot_pkg::*;
  localparam logic [15:0] DEV_ID = 16'h5A17; // Arbitrary value
  localparam logic [31:0] INIT_SEQ [16] = '{
    32'h0211_0014, 32'h026E_0064, 32'h026F_00EA, 32'h0270_1F16,
    32'h0410_2080, 32'h0418_2080, 32'h0420_2080, 32'h0441_C759,
    32'h0442_2A08, 32'h0443_5CFA, 32'h047E_080E, 32'h04B8_1120,
    32'h04E4_0E0D, 32'h04E5_0E0D, 32'h04E6_0E0D, 32'h04EB_060E
  };
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sleep_req = 1'b0;
  logic        clk_en = 1'b1;
  logic        drive_en = 1'b1;
  logic        drive_lvl = 1'b1;
  logic        pin_level, pin_driven, rvalid, irq_n, gpio_boot, boot_complete_flag;
  logic        core_rst_n, mic_analogue_a, mic_analogue_b;
  logic        dmic_clk_a_en, dmic_clk_b_en;
  logic [15:0] rdata;
  reg_req_t    req = '0;
  pad_ctrl_t   rst_pad;
  int          mismatches = 0;
  int          cmp_count = 0;

  always #2 sys_clk = ~sys_clk;

  host_reset_pin host (.drive_en(drive_en), .drive_lvl(drive_lvl), .pad(rst_pad),
                       .pin_level(pin_level), .pin_driven(pin_driven));
  reset_boot_and_device_id #(.DEVICE_ID(DEV_ID), .SILICON_REV(8'h3C), .DRIVER_REV(8'hC5)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .rst_pin_in(pin_level),
    .rst_pin_driven(pin_driven), .sleep_req(sleep_req), .req(req), .rdata(rdata),
    .rvalid(rvalid), .rst_pad(rst_pad), .irq_n(irq_n), .gpio_boot(gpio_boot),
    .boot_complete_flag(boot_complete_flag), .core_rst_n(core_rst_n),
    .mic_analogue_a(mic_analogue_a), .mic_analogue_b(mic_analogue_b),
    .digital_mic_clock_a_en(dmic_clk_a_en), .digital_mic_clock_b_en(dmic_clk_b_en));

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", n, exp, seen);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk) req = '0;
  endtask

  // Read data only counts when the valid pulse is there in the answer cycle
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string n);
    @(negedge sys_clk) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge sys_clk) req = '0;
    chk(n, (rvalid === 1'b1) ? rdata : 16'hXXXX, exp);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wait_boot;
    for (int i = 0; i < 400 && boot_complete_flag !== 1'b1; i++) @(negedge sys_clk);
    if (boot_complete_flag !== 1'b1) begin
      chk("boot flag timeout", {15'h0, boot_complete_flag}, 16'h0001);
      print_verdict();
    end
  endtask

  task automatic t_power_on;
    chk("flag in boot", {15'h0, boot_complete_flag}, 16'h0000);
    chk("irq in boot", {15'h0, irq_n}, 16'h0001);
    wait_boot();
    cycles(1);
    chk("irq after boot", {15'h0, irq_n}, 16'h0000);
    chk("gpio after boot", {15'h0, gpio_boot}, 16'h0001);
    chk("mic pins", {12'h0, mic_analogue_a, mic_analogue_b, dmic_clk_a_en, dmic_clk_b_en},
        16'h000C);
    rd(16'h0D23, 16'h0100, "raw status");
    rd(16'h0000, DEV_ID, "device id");
    rd(16'h0001, 16'h003C, "silicon rev");
    rd(16'h0002, 16'h00C5, "driver rev");
    rd(16'h0C20, 16'h0002, "pad default");
    rd(16'h0005, 16'h0000, "unmapped");
    wr(16'h0001, 16'hFFFF);
    rd(16'h0001, 16'h003C, "silicon rev ro");
    // After boot and the first register checks, host sends the full initialisation list
    foreach (INIT_SEQ[i]) wr(INIT_SEQ[i][31:16], INIT_SEQ[i][15:0]);
    wr(16'h3000, 16'h1234);
    $display("test power_on done");
  endtask

  task automatic t_hard_reset;
    drive_lvl = 1'b0;
    cycles(4);
    chk("core reset pin", {15'h0, core_rst_n}, 16'h0000);
    chk("flag pin reset", {15'h0, boot_complete_flag}, 16'h0000);
    cycles(20);
    chk("core reset held", {15'h0, core_rst_n}, 16'h0000);
    drive_lvl = 1'b1;
    cycles(8);
    chk("flag in boot", {15'h0, boot_complete_flag}, 16'h0000);
    rd(16'h0D23, 16'h0000, "raw status boot");
    wait_boot();
    rd(16'h3000, 16'h1234, "seq mem hard");
    $display("test hard_reset done");
  endtask

  task automatic t_soft_reset;
    wr(16'h0D33, 16'h0100);
    wr(16'h0C30, 16'h0003);
    chk("dmic enabled", {14'h0, dmic_clk_a_en, dmic_clk_b_en}, 16'h0003);
    wr(16'h0000, 16'h0000);
    cycles(1);
    chk("flag soft", {15'h0, boot_complete_flag}, 16'h0000);
    wr(16'h0C30, 16'h0003);
    wait_boot();
    rd(16'h0C30, 16'h0000, "mic reg soft");
    rd(16'h3000, 16'h1234, "seq mem soft");
    rd(16'h0000, DEV_ID, "id after write");
    chk("irq masked", {15'h0, irq_n}, 16'h0001);
    wr(16'h0D33, 16'h0000);
    chk("irq unmasked", {15'h0, irq_n}, 16'h0000);
    $display("test soft_reset done");
  endtask

  task automatic t_sleep;
    wr(16'h0C20, 16'h0003);
    wr(16'h0C30, 16'h0001);
    sleep_req = 1'b1;
    cycles(4);
    chk("flag sleep", {15'h0, boot_complete_flag}, 16'h0000);
    sleep_req = 1'b0;
    wait_boot();
    rd(16'h0C20, 16'h0003, "pad kept");
    rd(16'h0C30, 16'h0000, "mic reg wake");
    rd(16'h3000, 16'h1234, "seq mem wake");
    $display("test sleep done");
  endtask

  task automatic t_keeper;
    // A write while the clock enable is low must leave the pad bits alone
    clk_en = 1'b0;
    wr(16'h0C20, 16'h0000);
    clk_en = 1'b1;
    rd(16'h0C20, 16'h0003, "pad frozen");
    chk("keeper on", {15'h0, rst_pad.keep_en}, 16'h0001);
    drive_en = 1'b0;
    cycles(20);
    chk("keeper holds high", {15'h0, core_rst_n}, 16'h0001);
    drive_en = 1'b1;
    wr(16'h0C20, 16'h0001);
    chk("pulldown only", {14'h0, rst_pad.pu_en, rst_pad.pd_en}, 16'h0001);
    drive_en = 1'b0;
    cycles(6);
    chk("pulldown resets", {15'h0, core_rst_n}, 16'h0000);
    drive_en = 1'b1;
    wait_boot();
    wr(16'h0C20, 16'h0002);
    chk("pullup only", {14'h0, rst_pad.pu_en, rst_pad.pd_en}, 16'h0002);
    $display("test keeper done");
  endtask

  initial begin
    cycles(12);
    resetn = 1'b1;
    cycles(2);
    t_power_on();
    t_hard_reset();
    t_soft_reset();
    t_sleep();
    t_keeper();
    print_verdict();
  end
endmodule
